// ==== hw/vectored_irq_ctrl_map.vh ====
// Register offsets, field positions, reset values and sizes of the controller.
`ifndef VECTORED_IRQ_CTRL_MAP_VH
`define VECTORED_IRQ_CTRL_MAP_VH
`define NUM_SRC        32
`define NUM_INT_SRC    16
`define NUM_EXT_SRC    4
`define FIRST_EXT_SRC  16
`define FAST_SRC       0
`define FIRST_STD_SRC  1
`define OFS_SRC_MODE   12'h000
`define OFS_ENABLE     12'h080
`define OFS_PENDING    12'h084
`define OFS_VECTOR     12'h088
`define OFS_FAST_CTRL  12'h08c
`define OFS_INT_STAT   12'h090
`define OFS_INT_MASK   12'h094
`define OFS_EOI        12'h098
`define OFS_CURR_LVL   12'h09c
`define MODE_PRIO_LSB  0
`define MODE_PRIO_MSB  2
`define MODE_TYPE_LSB  5
`define MODE_TYPE_MSB  6
`define TYPE_LOW_LVL   2'h0
`define TYPE_FALL_EDGE 2'h1
`define TYPE_HIGH_LVL  2'h2
`define TYPE_RISE_EDGE 2'h3
`define MODE_RESET     32'h00000000
`define ENABLE_RESET   32'h00000000
`define MASK_RESET     32'h00000000
`define STAT_ENTRY     0
`define STAT_FAST      1
`define STAT_WAKE      2
`define STAT_SPUR      3
`define STAT_BITS      4
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ==== hw/src_mode_mem.v ====
// Small register memory holding the per-source mode words.
`timescale 1ns/1ps
`include "vectored_irq_ctrl_map.vh"
module src_mode_mem (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        clkEn,
   input  wire        wrEn,
   input  wire [4:0]  wrAddr,
   input  wire [31:0] wrData,
   input  wire [3:0]  wrStrb,
   input  wire [4:0]  rdAddr,
   output reg  [31:0] rdData_q,
   output wire [255:0] prioFlat,
   output wire [63:0]  typeFlat
);
   reg [31:0] modeMem_q [0:31];
   genvar i;
   // Each entry is written byte by byte and exposes its fields flat.
   generate
      for (i = 0; i < 32; i = i + 1) begin : gEntry
         integer b;
         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               modeMem_q[i] <= `MODE_RESET;
            end else if (clkEn && wrEn && wrAddr == i) begin
               for (b = 0; b < 4; b = b + 1) begin
                  if (wrStrb[b]) begin
                     modeMem_q[i][b*8 +: 8] <= wrData[b*8 +: 8];
                  end
               end
            end
         end
         assign prioFlat[i*8 +: 8] = {5'h00,
            modeMem_q[i][`MODE_PRIO_MSB:`MODE_PRIO_LSB]};
         assign typeFlat[i*2 +: 2] =
            modeMem_q[i][`MODE_TYPE_MSB:`MODE_TYPE_LSB];
      end
   endgenerate
   // Read data leave through a register.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_q <= 32'h00000000;
      end else if (clkEn) begin
         rdData_q <= modeMem_q[rdAddr];
      end
   end
endmodule // src_mode_mem

// ==== hw/vectored_irq_ctrl.v ====
// Vectored priority interrupt controller with an AXI4-Lite register port.
// Notes on behaviour
// RULE1 - The fast core request comes only from the external fast request pin.
// RULE2 - The standard core request rises for any peripheral or external line; the code holds it off while a source of equal or higher priority is in service.
// RULE3 - Every standard source carries one of eight programmable priorities.
// RULE4 - Each source has its own enable and the vector names the served one.
// RULE5 - Internal sources are chosen level or edge sensitive by software.
// RULE6 - External lines detect rising, falling, high or low as programmed.
// RULE7 - Each parallel port controller presents one request into the block.
// RULE8 - Each timer counter channel presents its own request into the block.
// RULE9 - Any enabled pending request wakes a stopped core clock.
// RULE10 - Highest priority wins and ties go to the lowest source number.
`timescale 1ns/1ps
`include "vectored_irq_ctrl_map.vh"
module vectored_irq_ctrl (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        clkEn,
   input  wire [1:0]  portReq,
   input  wire [5:0]  timerReq,
   input  wire [6:0]  periphReq,
   input  wire [3:0]  extRequest,
   input  wire        extFastRequest,
   output reg         core_fast_irq_n,
   output reg         core_std_irq_n,
   output reg         coreWake,
   output reg         irqOut,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   reg  [4:0]  extSync1_q;
   reg  [4:0]  extSync2_q;
   reg  [4:0]  extPrev_q;
   reg  [31:0] rawPrev_q;
   reg  [31:0] edgeLatch_q;
   reg  [31:0] enable_q;
   reg  [31:0] intStat_q;
   reg  [31:0] intMask_q;
   reg  [4:0]  vector_q;
   reg  [2:0]  currLvl_q;
   reg         inService_q;
   reg  [11:0] awAddr_q;
   reg         awHeld_q;
   reg  [31:0] wData_q;
   reg  [3:0]  wStrb_q;
   reg         wHeld_q;
   reg  [11:0] arAddr_q;
   reg         rdPend_q;
   wire [31:0] modeRd;
   wire [4:0]  modeRdAddr;
   wire [255:0] prioFlat;
   wire [63:0]  typeFlat;
   wire [31:0] rawReq;
   wire [31:0] detect;
   reg  [31:0] pending;
   reg  [31:0] edgeClr;
   reg  [4:0]  bestSrc;
   reg  [2:0]  bestLvl;
   reg         bestHit;
   reg  [3:0]  statSet;
   integer     k;
   wire        doWrite;
   wire        modeWr;
   wire        readVec;
   wire        writeEoi;

   // Source vector: fast pin, peripherals, ports, timers, external lines.
   assign rawReq = {12'h000, extSync2_q[3:0], timerReq, portReq,
                    periphReq, extSync2_q[4]}; // [RULE7] [RULE8]

   // The mode memory is addressed as the read address is taken, so that
   // its registered data already stand when the answer is built.
   assign modeRdAddr = (s_axi_arvalid && s_axi_arready) ?
                       s_axi_araddr[6:2] : arAddr_q[6:2];

   // External request pins pass two flip-flops before any logic reads them; peripheral, port and timer requests enter directly.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         extSync1_q <= 5'h00;
         extSync2_q <= 5'h00;
         extPrev_q  <= 5'h00;
         rawPrev_q  <= 32'h00000000;
      end else if (clkEn) begin
         extSync1_q <= {extFastRequest, extRequest};
         extSync2_q <= extSync1_q;
         extPrev_q  <= extSync2_q;
         rawPrev_q  <= rawReq;
      end
   end

   src_mode_mem uModeMem (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .wrEn     (modeWr),
      .wrAddr   (awAddr_q[6:2]),
      .wrData   (wData_q),
      .wrStrb   (wStrb_q),
      .rdAddr   (modeRdAddr),
      .rdData_q (modeRd),
      .prioFlat (prioFlat),
      .typeFlat (typeFlat)
   );

   // Per source detection; internal sources only use bit 1 of the type.
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : gDet
         wire [1:0] typ = typeFlat[g*2 +: 2];
         wire       isExt = (g == `FAST_SRC) ||
                            (g >= `FIRST_EXT_SRC &&
                             g < `FIRST_EXT_SRC + `NUM_EXT_SRC);
         wire       rise = rawReq[g] & ~rawPrev_q[g];
         wire       fall = ~rawReq[g] & rawPrev_q[g];
         wire       lvl = isExt ? (typ == `TYPE_HIGH_LVL ? rawReq[g] :
                                   ~rawReq[g]) : rawReq[g]; // [RULE6]
         wire       isEdge = isExt ? typ[0] : typ[1]; // [RULE5]
         wire       edgeHit = (isExt && typ == `TYPE_FALL_EDGE) ? fall :
                              rise; // [RULE6]
         assign detect[g] = isEdge ? (edgeLatch_q[g] | edgeHit) : lvl;
         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               edgeLatch_q[g] <= 1'b0;
            end else if (clkEn) begin
               if (isEdge && edgeHit) begin
                  edgeLatch_q[g] <= 1'b1;
               end else if (edgeClr[g] || !isEdge) begin
                  edgeLatch_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Priority search over all enabled standard sources, whatever the current level.
   always @* begin
      pending = detect & enable_q; // [RULE4]
      bestSrc = 5'h00;
      bestLvl = 3'h0;
      bestHit = 1'b0;
      for (k = `FIRST_STD_SRC; k < `NUM_SRC; k = k + 1) begin
         if (pending[k] && (!bestHit || prioFlat[k*8 +: 3] > bestLvl))
         begin
            bestSrc = k[4:0]; // [RULE10]
            bestLvl = prioFlat[k*8 +: 3]; // [RULE3]
            bestHit = 1'b1;
         end
      end
   end

   assign doWrite  = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign modeWr   = doWrite && awAddr_q[11:7] == 5'h00;
   assign readVec  = rdPend_q && !s_axi_rvalid && arAddr_q == `OFS_VECTOR;
   assign writeEoi = doWrite && awAddr_q == `OFS_EOI;

   // Reading the vector clears its edge latch and enters service.
   always @* begin
      edgeClr = 32'h00000000;
      if (readVec && bestHit) begin
         edgeClr[bestSrc] = 1'b1;
      end
      if (doWrite && awAddr_q == `OFS_FAST_CTRL) begin
         edgeClr[`FAST_SRC] = 1'b1;
      end
      statSet = 4'h0;
      statSet[`STAT_ENTRY] = readVec && bestHit;
      statSet[`STAT_SPUR]  = readVec && !bestHit;
      // The fast line still high means this is the first pending cycle.
      statSet[`STAT_FAST]  = pending[`FAST_SRC] & core_fast_irq_n;
      statSet[`STAT_WAKE]  = (|pending) && !coreWake;
   end

   // Core lines, service state, enables and sticky status.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         core_fast_irq_n <= 1'b1;
         core_std_irq_n  <= 1'b1;
         coreWake        <= 1'b0;
         irqOut          <= 1'b0;
         enable_q        <= `ENABLE_RESET;
         intMask_q       <= `MASK_RESET;
         intStat_q       <= 32'h00000000;
         vector_q        <= 5'h00;
         currLvl_q       <= 3'h0;
         inService_q     <= 1'b0;
      end else if (clkEn) begin
         core_fast_irq_n <= ~pending[`FAST_SRC]; // [RULE1]
         core_std_irq_n  <= ~(bestHit && (!inService_q ||
                              bestLvl > currLvl_q)); // [RULE2]
         coreWake        <= |pending; // [RULE9]
         irqOut          <= |(intStat_q[`STAT_BITS-1:0] &
                              intMask_q[`STAT_BITS-1:0]);
         if (readVec && bestHit) begin
            vector_q    <= bestSrc; // [RULE4]
            currLvl_q   <= bestLvl;
            inService_q <= 1'b1;
         end else if (writeEoi) begin
            inService_q <= 1'b0;
            currLvl_q   <= 3'h0;
         end
         if (doWrite && awAddr_q == `OFS_ENABLE) begin
            enable_q <= wData_q;
         end
         if (doWrite && awAddr_q == `OFS_INT_MASK) begin
            intMask_q <= {28'h0000000, wData_q[`STAT_BITS-1:0]};
         end
         // A new event wins over a write-one clear in the same cycle.
         if (doWrite && awAddr_q == `OFS_INT_STAT) begin
            intStat_q <= {28'h0000000, (intStat_q[`STAT_BITS-1:0] &
                         ~wData_q[`STAT_BITS-1:0]) | statSet};
         end else begin
            intStat_q <= {28'h0000000,
                          intStat_q[`STAT_BITS-1:0] | statSet};
         end
      end
   end

   // AXI4-Lite write side: address and data taken in either order.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 12'h000;
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
      end else if (clkEn) begin
         s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q[11:7] == 5'h00 ||
                             (awAddr_q >= `OFS_ENABLE &&
                              awAddr_q <= `OFS_CURR_LVL)) ?
                            `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side: data one cycle after the address is taken.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
         arAddr_q      <= 12'h000;
         rdPend_q      <= 1'b0;
      end else if (clkEn) begin
         s_axi_arready <= !rdPend_q && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            arAddr_q <= s_axi_araddr;
            rdPend_q <= 1'b1;
         end
         if (rdPend_q && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (arAddr_q)
               `OFS_ENABLE:   s_axi_rdata <= enable_q;
               `OFS_PENDING:  s_axi_rdata <= pending;
               `OFS_VECTOR:   s_axi_rdata <= {27'h0000000,
                                 bestHit ? bestSrc : 5'h00};
               `OFS_FAST_CTRL: s_axi_rdata <= {31'h00000000,
                                 pending[`FAST_SRC]};
               `OFS_INT_STAT: s_axi_rdata <= intStat_q;
               `OFS_INT_MASK: s_axi_rdata <= intMask_q;
               `OFS_EOI:      s_axi_rdata <= {27'h0000000, vector_q};
               `OFS_CURR_LVL: s_axi_rdata <= {28'h0000000, inService_q,
                                 currLvl_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
            // Mode words come from the memory's registered read port.
            if (arAddr_q[11:7] == 5'h00) begin
               s_axi_rdata <= modeRd; // [RULE3]
               s_axi_rresp <= `RESP_OKAY;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rdPend_q     <= 1'b0;
         end
      end
   end

endmodule // vectored_irq_ctrl

// ==== tb/vectored_irq_ctrl_checker.sv ====
// Port-level assertions for the vectored interrupt controller.
`timescale 1ns/1ps
module vectored_irq_ctrl_checker (
   input wire        sys_clk,
   input wire        arst_n,
   input wire [1:0]  portReq,
   input wire [5:0]  timerReq,
   input wire [6:0]  periphReq,
   input wire [3:0]  extRequest,
   input wire        extFastRequest,
   input wire        core_fast_irq_n,
   input wire        core_std_irq_n,
   input wire        coreWake,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid
);
   wire [19:0] srcNow = {extRequest, timerReq, portReq, periphReq,
                         extFastRequest};
   wire        wrHs   = s_axi_wvalid & s_axi_wready;
   wire        rdHs   = s_axi_arvalid & s_axi_arready;
   reg  [19:0] srcPrev_q;
   reg  [3:0]  fastQuiet_q;
   reg  [3:0]  allQuiet_q;
   // Counts cycles since a source pin or a bus access last moved.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         srcPrev_q   <= 20'h00000;
         fastQuiet_q <= 4'h0;
         allQuiet_q  <= 4'h0;
      end else begin
         srcPrev_q   <= srcNow;
         fastQuiet_q <= (wrHs || srcNow[0] != srcPrev_q[0]) ? 4'h0
                        : fastQuiet_q + {3'h0, fastQuiet_q != 4'hf};
         allQuiet_q  <= (wrHs || rdHs || srcNow != srcPrev_q) ? 4'h0
                        : allQuiet_q + {3'h0, allQuiet_q != 4'hf};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_fast_pin_only: assert property (fastQuiet_q > 4'h8
      |-> $stable(core_fast_irq_n)) else $error("fast line moved alone");
   a_std_from_src: assert property (allQuiet_q > 4'h8
      |-> $stable(core_std_irq_n)) else $error("std line moved alone");
   a_wake_from_src: assert property (allQuiet_q > 4'h8
      |-> $stable(coreWake)) else $error("wake moved alone");
   a_wake_on_irq: assert property ($fell(core_std_irq_n)
      || $fell(core_fast_irq_n) |-> coreWake) else $error("irq without wake");
   a_read_answer: assert property (rdHs |-> ##[1:3] s_axi_rvalid)
      else $error("read not answered");
   a_write_answer: assert property (wrHs |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");
   a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready held");
   a_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
      else $error("wready held");
   c_fast: cover property (!core_fast_irq_n);
   c_std: cover property ($fell(core_std_irq_n));
   c_read: cover property (rdHs ##[1:3] s_axi_rvalid);
endmodule // vectored_irq_ctrl_checker
bind vectored_irq_ctrl vectored_irq_ctrl_checker u_vectored_irq_ctrl_checker (.*);

// ==== tb/core_model.sv ====
// Behavioural core clock that stops on request and wakes on interrupt.
`timescale 1ns/1ps
module core_model (
   input  wire sys_clk,
   input  wire arst_n,
   input  wire coreWake,
   input  wire stopReq,
   output reg  coreRun_q
);
   // Hardware reset or any enabled interrupt restarts the core clock.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         coreRun_q <= 1'b1;
      else if (coreWake)
         coreRun_q <= 1'b1;
      else if (stopReq)
         coreRun_q <= 1'b0;
   end
endmodule // core_model

// ==== tb/test_vectored_irq_ctrl.sv ====
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
`include "vectored_irq_ctrl_map.vh"
module test_vectored_irq_ctrl;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        clkEn = 1'b1;
   logic        stopReq = 1'b0;
   logic        extFastRequest = 1'b0;
   logic [1:0]  portReq = 2'h0;
   logic [5:0]  timerReq = 6'h00;
   logic [6:0]  periphReq = 7'h00;
   logic [3:0]  extRequest = 4'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   wire         core_fast_irq_n, core_std_irq_n, coreWake, irqOut;
   wire         coreRun_q, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire         s_axi_arready, s_axi_rvalid;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   int          n_mismatch = 0, checked = 0;
   vectored_irq_ctrl u_vectored_irq_ctrl (.*);
   core_model u_core_model (.*);
   // Free-running system clock.
   always #4 sys_clk = ~sys_clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input logic [31:0] g, e, input string m);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   function automatic logic [11:0] ma(input int s);
      return `OFS_SRC_MODE + 12'(4 * s);
   endfunction
   task automatic drv(input logic [19:0] r);
      periphReq <= r[7:1];
      portReq <= r[9:8];
      timerReq <= r[15:10];
      extRequest <= r[19:16];
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = `RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e, "read data");
      chk(s_axi_rresp, er, "read resp");
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = `RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge sys_clk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "write resp");
      @(posedge sys_clk);
   endtask
   task automatic t_regs;
      rd(`OFS_ENABLE, `ENABLE_RESET);
      rd(`OFS_INT_MASK, `MASK_RESET);
      rd(ma(5), `MODE_RESET);
      rd(12'hffc, 32'h0, `RESP_SLVERR);
      wr(12'hffc, 32'h1, `RESP_SLVERR);
   endtask
   task automatic t_std;
      wr(ma(1), 32'h3);
      rd(ma(1), 32'h3);
      drv(20'h00002);
      stopReq <= 1'b1;
      cyc(6);
      stopReq <= 1'b0;
      chk(core_std_irq_n, 1'b1, "masked source");
      chk(coreRun_q, 1'b0, "core stopped");
      wr(`OFS_ENABLE, 32'h2);
      cyc(6);
      chk(core_std_irq_n, 1'b0, "std low");
      chk(core_fast_irq_n, 1'b1, "fast quiet");
      chk(coreRun_q, 1'b1, "core woken");
      chk(coreWake, 1'b1, "wake high");
      rd(`OFS_PENDING, 32'h2);
      rd(`OFS_VECTOR, 32'd1);
      rd(`OFS_CURR_LVL, 32'hb);
      drv(20'h00000);
      wr(`OFS_EOI, 32'h0);
   endtask
   task automatic t_prio;
      int sa[3] = '{8, 8, 9};
      int sb[3] = '{10, 10, 15};
      int pa[3] = '{2, 4, 7};
      int pb[3] = '{5, 4, 0};
      int ev[3] = '{10, 8, 9};
      for (int i = 0; i < 3; i++) begin
         wr(ma(sa[i]), pa[i]);
         wr(ma(sb[i]), pb[i]);
         wr(`OFS_ENABLE, (32'h1 << sa[i]) | (32'h1 << sb[i]));
         drv((20'h1 << sa[i]) | (20'h1 << sb[i]));
         cyc(6);
         rd(`OFS_VECTOR, ev[i]);
         drv(20'h00000);
         wr(`OFS_EOI, 32'h0);
      end
   endtask
   task automatic t_edge;
      wr(ma(12), 32'h41);
      wr(`OFS_ENABLE, 32'h1000);
      drv(20'h01000);
      cyc(1);
      drv(20'h00000);
      cyc(6);
      chk(core_std_irq_n, 1'b0, "edge held");
      rd(`OFS_VECTOR, 32'd12);
      wr(`OFS_EOI, 32'h0);
      cyc(4);
      chk(core_std_irq_n, 1'b1, "edge cleared");
   endtask
   task automatic t_ext;
      logic [1:0] ty;
      for (int i = 0; i < 4; i++) begin
         ty = 2'(i);
         wr(`OFS_ENABLE, 32'h0);
         wr(ma(16), {25'h0, ty, 5'h01});
         drv({3'h0, !ty[1], 16'h0000});
         cyc(6);
         wr(`OFS_ENABLE, 32'h10000);
         cyc(6);
         chk(core_std_irq_n, 1'b1, "ext idle");
         drv({3'h0, ty[1], 16'h0000});
         cyc(6);
         chk(core_std_irq_n, 1'b0, "ext active");
         drv({3'h0, !ty[1], 16'h0000});
         cyc(6);
         chk(core_std_irq_n, !ty[0], "ext release");
         if (ty[0])
            rd(`OFS_VECTOR, 32'd16);
         wr(`OFS_EOI, 32'h0);
      end
   endtask
   task automatic t_fast;
      wr(ma(0), 32'h60);
      wr(`OFS_ENABLE, 32'h1);
      drv(20'hffffe);
      extFastRequest <= 1'b1;
      cyc(6);
      chk(core_fast_irq_n, 1'b0, "fast low");
      chk(core_std_irq_n, 1'b1, "std quiet");
      chk(irqOut, 1'b0, "irq masked");
      wr(`OFS_INT_MASK, 32'h2);
      cyc(3);
      chk(irqOut, 1'b1, "irq raised");
      extFastRequest <= 1'b0;
      wr(`OFS_FAST_CTRL, 32'h0);
      wr(`OFS_INT_STAT, 32'h2);
      cyc(3);
      chk(core_fast_irq_n, 1'b1, "fast cleared");
      chk(irqOut, 1'b0, "irq cleared");
   endtask
   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence: reset, then each scenario in turn.
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_std();
      t_prio();
      t_edge();
      t_ext();
      t_fast();
      conclude();
   end
   // Cuts a hung run short.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      conclude();
   end
endmodule // test_vectored_irq_ctrl
